// ### include/uebc_pkg.sv
`default_nettype none
package uebc_pkg;
  // ********
  // Special function register addresses
  // ********
  localparam logic [7:0] SFR_EPBC = 8'hc1;
  localparam logic [7:0] SFR_EPBS = 8'hc2;
  localparam logic [7:0] SFR_ENDPOINT_SELECTOR = 8'hd2;
  localparam logic [7:0] SFR_OFFSET = 8'hd3;
  localparam logic [7:0] SFR_DATA_PORT = 8'hd4;

  // ********
  // Sizes
  // ********
  localparam int NUM_EP = 5;
  localparam int EP_W = 3;
  localparam int OFF_W = 4;
  localparam int MEM_AW = EP_W + 1 + OFF_W;
  localparam int MEM_DEPTH = 1 << MEM_AW;
  localparam logic [7:0] EP_COUNT = 8'h05;

  // ********
  // Buffer control bit positions and reset
  // ********
  localparam int BC_HALT = 7;
  localparam int BC_GATE = 6;
  localparam int BC_SOF = 5;
  localparam int BC_INC = 1;
  localparam int BC_DBM = 0;
  localparam logic [7:0] BC_RESET = 8'h00;

  // ********
  // Buffer status bit positions and reset
  // ********
  localparam int BS_UFULL = 7;
  localparam int BS_CFULL = 6;
  localparam int BS_DIR = 5;
  localparam int BS_ESP = 4;
  localparam int BS_PRD = 3;
  localparam int BS_PWR = 2;
  localparam int BS_FLUSH = 1;
  localparam int BS_DONE = 0;
  localparam logic [7:0] BS_RESET = 8'h20;

  // Flow direction codes
  localparam logic DIR_H2C = 1'b0;
  localparam logic DIR_C2H = 1'b1;

  // Status phase sequencer states
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_AUTO = 2'b01,
    ST_SW = 2'b11
  } uebc_stat_t;
endpackage
`default_nettype wire

// ### include/uebc_mem_if.sv
`timescale 1ns/10ps
`default_nettype none
// Endpoint memory ports between controller and storage
interface uebc_mem_if import uebc_pkg::*; ();
  logic [MEM_AW-1:0] cpu_addr;
  logic [MEM_AW-1:0] usb_addr;
  logic cpu_we;
  logic usb_we;
  logic [7:0] cpu_wdata;
  logic [7:0] usb_wdata;
  logic [7:0] cpu_rdata;
  logic [7:0] usb_rdata;
  modport ctl (output cpu_addr, usb_addr, cpu_we, usb_we, cpu_wdata,
    usb_wdata, input cpu_rdata, usb_rdata);
  modport mem (input cpu_addr, usb_addr, cpu_we, usb_we, cpu_wdata,
    usb_wdata, output cpu_rdata, usb_rdata);
endinterface
`default_nettype wire

// ### core/uebc_bufmem.sv
`timescale 1ns/10ps
`default_nettype none
module uebc_bufmem import uebc_pkg::*; (
  input wire logic clk, // Module clock
  input wire logic rst, // Async reset, high
  uebc_mem_if.mem bus // Memory ports
);
  // ********
  // Storage
  // ********
  logic [7:0] mem_reg [MEM_DEPTH];
  logic [7:0] usb_q_reg;

  // Both writers; USB wins a same-address collision since the host
  // cannot be held off
  always_ff @(posedge clk) begin
    if (bus.cpu_we) begin
      mem_reg[bus.cpu_addr] <= bus.cpu_wdata;
    end
    if (bus.usb_we) begin
      mem_reg[bus.usb_addr] <= bus.usb_wdata;
    end
  end

  // USB read data is registered
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      usb_q_reg <= 8'h00;
    end else begin
      usb_q_reg <= mem_reg[bus.usb_addr];
    end
  end

  // CPU side reads straight from the flops
  assign bus.cpu_rdata = mem_reg[bus.cpu_addr];
  assign bus.usb_rdata = usb_q_reg;
endmodule
`default_nettype wire

// ### core/uebc_status_phase.sv
`timescale 1ns/10ps
`default_nettype none
module uebc_status_phase import uebc_pkg::*; (
  input wire logic clk, // Module clock
  input wire logic rst, // Async reset, high
  input wire logic [EP_W-1:0] ep, // Endpoint of event
  input wire logic req, // Status phase begins
  input wire logic done, // Status phase completed
  input wire logic [NUM_EP-1:0] esp, // Auto-ack armed
  input wire logic [NUM_EP-1:0] halt, // Endpoint halted
  output logic ack, // Auto ACK pulse
  output logic stall, // Stall answer pulse
  output logic [NUM_EP-1:0] esp_clr, // Disarm pulse
  output logic irq // Status phase irq pulse
);
  uebc_stat_t state_reg;
  logic [EP_W-1:0] ep_reg;
  logic ok;

  assign ok = {5'h00, ep} < EP_COUNT;

  // ********
  // Sequencer
  // ********
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_reg <= ST_IDLE;
      ep_reg <= '0;
      ack <= 1'b0;
      stall <= 1'b0;
      esp_clr <= '0;
      irq <= 1'b0;
    end else begin
      ack <= 1'b0;
      stall <= 1'b0;
      esp_clr <= '0;
      irq <= 1'b0;
      unique case (state_reg)
        ST_IDLE: begin
          if (req && ok) begin
            ep_reg <= ep;
            if (halt[ep]) begin
              stall <= 1'b1;
            end else if (esp[ep]) begin
              ack <= 1'b1;
              state_reg <= ST_AUTO;
            end else begin
              state_reg <= ST_SW;
            end
          end
        end
        ST_AUTO: begin
          if (done) begin
            esp_clr[ep_reg] <= 1'b1;
            state_reg <= ST_IDLE;
          end
        end
        ST_SW: begin
          if (done) begin
            irq <= 1'b1;
            state_reg <= ST_IDLE;
          end
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end
endmodule
`default_nettype wire

// ### core/uebc_top.sv
// How it works
// - Halt bit set means endpoint stalled, clear means active.
// - Endpoint 0 halt clears itself on the next setup token.
// - Endpoint interrupt passes only while its gate bit is one.
// - With frame auto-complete on, each frame start acts as buffer done.
// - Auto-step bumps the CPU offset after each data port access.
// - Each offset change reloads the data port from memory.
// - Double buffer select: zero single buffer, one dual buffer.
// - USB-side full flag shows the buffer the USB side uses.
// - CPU-side full flag shows the buffer the CPU side uses.
// - Direction bit: zero host to CPU, one CPU to host.
// - Armed auto-ack answers the next status phase with ACK.
// - No auto-ack while the endpoint is halted.
// - Completed auto status phase disarms itself, raises no irq.
// - Auto-ack arm is write only and reads back zero.
// - Predict-read asks for CPU to host direction next.
// - Direction changes only while both buffers are empty.
// - Predict-write asks for host to CPU direction next.
// - Flush zeroes offset and full flags, keeps direction, reads zero.
// - Buffer done tags the CPU buffer full or empty, reads zero.
`timescale 1ns/10ps
`default_nettype none
module uebc_top import uebc_pkg::*; (
  input wire logic clk, // Module clock
  input wire logic rst, // Async reset, high
  input wire logic [7:0] sfr_addr, // Register address
  input wire logic [7:0] sfr_wdata, // Register write data
  input wire logic sfr_wr, // Write strobe
  input wire logic sfr_rd, // Read strobe
  output logic [7:0] sfr_rdata, // Read data, next cycle
  input wire logic [EP_W-1:0] usb_ep, // Endpoint of USB event
  input wire logic usb_setup, // Setup token pulse
  input wire logic usb_sof, // Start of frame pulse
  input wire logic usb_token, // Data token pulse
  input wire logic usb_token_rd, // Token is a host read
  input wire logic usb_wr_done, // Host filled a buffer
  input wire logic usb_rd_done, // Host drained a buffer
  input wire logic usb_mem_we, // USB memory write
  input wire logic [MEM_AW-1:0] usb_mem_addr, // USB memory address
  input wire logic [7:0] usb_mem_wdata, // USB write byte
  output logic [7:0] usb_mem_rdata, // USB read byte
  input wire logic status_req, // Status phase begins
  input wire logic status_done, // Status phase completed
  output logic status_ack, // Auto ACK pulse
  output logic status_stall, // Stall answer pulse
  output logic status_phase_irq, // Status irq pulse
  input wire logic [NUM_EP-1:0] endpoint_irq_requests, // Request ORs
  output logic [NUM_EP-1:0] ep_irq, // Gated endpoint irqs
  output logic [NUM_EP-1:0] endpoint_halt, // Halt state
  output logic [NUM_EP-1:0] last_flow_direction, // Direction
  output logic [NUM_EP-1:0] usb_side_full, // USB buffer flags
  output logic [NUM_EP-1:0] double_buffer_sel // Buffer mode
);
  // ********
  // Shared registers and decode
  // ********
  logic [7:0] endpoint_selector_reg;
  logic [OFF_W-1:0] cpu_buffer_offset_reg;
  logic [OFF_W-1:0] cpu_buffer_offset_next;
  logic [7:0] buffer_data_port_reg;
  logic [7:0] rdata_reg;
  logic fetch_reg;
  logic off_change;
  logic [EP_W-1:0] sel_ep;
  logic sel_ok;
  logic wr_bc;
  logic wr_bs;
  logic wr_sel;
  logic wr_off;
  logic wr_data;
  logic rd_data;
  logic sel_flush;

  // Per-endpoint state
  logic [NUM_EP-1:0] endpoint_irq_gate;
  logic [NUM_EP-1:0] frame_auto_complete_en;
  logic [NUM_EP-1:0] offset_auto_step_en;
  logic [NUM_EP-1:0] status_phase_auto_ack;
  logic [NUM_EP-1:0] cpu_side_full;
  logic [NUM_EP-1:0] cpu_idx;
  logic [NUM_EP-1:0] usb_idx;
  logic [2*NUM_EP-1:0] buf_full;
  logic [NUM_EP-1:0] flush_vec;
  logic [NUM_EP-1:0] esp_clr;

  // Read views of the selected endpoint
  logic [7:0] bc_view;
  logic [7:0] bs_view;
  logic [7:0] rd_mux;

  uebc_mem_if mem_bus ();

  assign sel_ep = endpoint_selector_reg[EP_W-1:0];
  assign sel_ok = endpoint_selector_reg < EP_COUNT;

  // Register strobes
  assign wr_bc = sfr_wr && (sfr_addr == SFR_EPBC);
  assign wr_bs = sfr_wr && (sfr_addr == SFR_EPBS);
  assign wr_sel = sfr_wr && (sfr_addr == SFR_ENDPOINT_SELECTOR);
  assign wr_off = sfr_wr && (sfr_addr == SFR_OFFSET);
  assign wr_data = sfr_wr && (sfr_addr == SFR_DATA_PORT) && sel_ok;
  assign rd_data = sfr_rd && (sfr_addr == SFR_DATA_PORT) && sel_ok;
  assign sel_flush = |flush_vec;

  // ********
  // Per-endpoint control and status
  // ********
  for (genvar i = 0; i < NUM_EP; i++) begin : g_ep
    logic hit;
    logic bc_w;
    logic bs_w;
    logic done;
    logic u_ev;
    logic empty2;
    logic prd;
    logic pwr;
    logic [1:0] bf_now;
    logic [1:0] bf_next;

    // Each endpoint owns its copy; the selector picks one
    assign hit = sel_ok && (sel_ep == EP_W'(i));
    assign bc_w = wr_bc && hit;
    assign bs_w = wr_bs && hit;
    assign flush_vec[i] = bs_w && sfr_wdata[BS_FLUSH];
    assign done = (bs_w && sfr_wdata[BS_DONE])
      || (usb_sof && frame_auto_complete_en[i]);
    assign u_ev = usb_ep == EP_W'(i);
    assign bf_now = buf_full[2*i +: 2];
    assign empty2 = bf_now == 2'b00;
    // Predictions are dropped when flush comes in the same write
    assign prd = bs_w && sfr_wdata[BS_PRD] && !flush_vec[i];
    assign pwr = bs_w && sfr_wdata[BS_PWR] && !flush_vec[i];

    // Halt bit; a software write outranks the setup auto-clear
    always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
        endpoint_halt[i] <= BC_RESET[BC_HALT];
      end else if (bc_w) begin
        endpoint_halt[i] <= sfr_wdata[BC_HALT];
      end else if ((i == 0) && usb_setup && u_ev) begin
        endpoint_halt[i] <= 1'b0;
      end
    end

    // Configuration bits; reserved bits are not stored
    always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
        endpoint_irq_gate[i] <= BC_RESET[BC_GATE];
        frame_auto_complete_en[i] <= BC_RESET[BC_SOF];
        offset_auto_step_en[i] <= BC_RESET[BC_INC];
        double_buffer_sel[i] <= BC_RESET[BC_DBM];
      end else if (bc_w) begin
        endpoint_irq_gate[i] <= sfr_wdata[BC_GATE];
        frame_auto_complete_en[i] <= sfr_wdata[BC_SOF];
        offset_auto_step_en[i] <= sfr_wdata[BC_INC];
        double_buffer_sel[i] <= sfr_wdata[BC_DBM];
      end
    end

    // Buffer flags: clears first so a same-cycle fill survives
    always_comb begin
      bf_next = bf_now;
      if (done && (last_flow_direction[i] == DIR_H2C)) begin
        bf_next[cpu_idx[i]] = 1'b0;
      end
      if (usb_rd_done && u_ev) begin
        bf_next[usb_idx[i]] = 1'b0;
      end
      if (done && (last_flow_direction[i] == DIR_C2H)) begin
        bf_next[cpu_idx[i]] = 1'b1;
      end
      if (usb_wr_done && u_ev) begin
        bf_next[usb_idx[i]] = 1'b1;
      end
      if (flush_vec[i]) begin
        bf_next = 2'b00;
      end
    end

    always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
        buf_full[2*i +: 2] <= {BS_RESET[BS_CFULL], BS_RESET[BS_UFULL]};
      end else begin
        buf_full[2*i +: 2] <= bf_next;
      end
    end

    // Buffer ownership; single mode pins both sides to buffer 0
    always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
        cpu_idx[i] <= 1'b0;
        usb_idx[i] <= 1'b0;
      end else if (flush_vec[i] || !double_buffer_sel[i]) begin
        cpu_idx[i] <= 1'b0;
        usb_idx[i] <= 1'b0;
      end else begin
        if (done) begin
          cpu_idx[i] <= !cpu_idx[i];
        end
        if ((usb_wr_done || usb_rd_done) && u_ev) begin
          usb_idx[i] <= !usb_idx[i];
        end
      end
    end

    assign usb_side_full[i] = bf_now[usb_idx[i]];
    assign cpu_side_full[i] = bf_now[cpu_idx[i]];

    // Direction; the real token outranks a prediction
    always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
        last_flow_direction[i] <= BS_RESET[BS_DIR];
      end else if (empty2 && !flush_vec[i]) begin
        if (usb_token && u_ev) begin
          last_flow_direction[i] <= usb_token_rd ? DIR_C2H : DIR_H2C;
        end else if (prd && !pwr) begin
          last_flow_direction[i] <= DIR_C2H;
        end else if (pwr && !prd) begin
          last_flow_direction[i] <= DIR_H2C;
        end
      end
    end

    // Auto-ack arm; a write that arms wins over any disarm
    always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
        status_phase_auto_ack[i] <= BS_RESET[BS_ESP];
      end else if (bs_w && sfr_wdata[BS_ESP]) begin
        status_phase_auto_ack[i] <= 1'b1;
      end else if (esp_clr[i] || flush_vec[i]) begin
        status_phase_auto_ack[i] <= 1'b0;
      end
    end
  end

  // ********
  // Selector and CPU offset
  // ********
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      endpoint_selector_reg <= 8'h00;
    end else if (wr_sel) begin
      endpoint_selector_reg <= sfr_wdata;
    end
  end

  // Flush first, then a direct write, then the auto step
  always_comb begin
    cpu_buffer_offset_next = cpu_buffer_offset_reg;
    if (sel_flush) begin
      cpu_buffer_offset_next = '0;
    end else if (wr_off) begin
      cpu_buffer_offset_next = sfr_wdata[OFF_W-1:0];
    end else if ((wr_data || rd_data) && offset_auto_step_en[sel_ep]) begin
      cpu_buffer_offset_next = cpu_buffer_offset_reg + 1'b1;
    end
  end

  assign off_change = sel_flush || wr_off
    || ((wr_data || rd_data) && offset_auto_step_en[sel_ep]);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cpu_buffer_offset_reg <= '0;
      fetch_reg <= 1'b0;
    end else begin
      cpu_buffer_offset_reg <= cpu_buffer_offset_next;
      fetch_reg <= off_change;
    end
  end

  // ********
  // Data port and endpoint memory
  // ********
  // The fetch lands one cycle after the offset moves, so a read in
  // that very cycle still sees the old byte
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      buffer_data_port_reg <= 8'h00;
    end else if (wr_data) begin
      buffer_data_port_reg <= sfr_wdata;
    end else if (fetch_reg) begin
      buffer_data_port_reg <= mem_bus.cpu_rdata;
    end
  end

  assign mem_bus.cpu_addr = {sel_ep, cpu_idx[sel_ep], cpu_buffer_offset_reg};
  assign mem_bus.cpu_we = wr_data;
  assign mem_bus.cpu_wdata = sfr_wdata;
  assign mem_bus.usb_addr = usb_mem_addr;
  assign mem_bus.usb_we = usb_mem_we;
  assign mem_bus.usb_wdata = usb_mem_wdata;
  assign usb_mem_rdata = mem_bus.usb_rdata;

  uebc_bufmem u_mem (
    .clk(clk),
    .rst(rst),
    .bus(mem_bus.mem)
  );

  // ********
  // Read views and read data
  // ********
  // Reserved and strobe positions read as zero
  always_comb begin
    bc_view = 8'h00;
    bs_view = 8'h00;
    if (sel_ok) begin
      bc_view[BC_HALT] = endpoint_halt[sel_ep];
      bc_view[BC_GATE] = endpoint_irq_gate[sel_ep];
      bc_view[BC_SOF] = frame_auto_complete_en[sel_ep];
      bc_view[BC_INC] = offset_auto_step_en[sel_ep];
      bc_view[BC_DBM] = double_buffer_sel[sel_ep];
      bs_view[BS_UFULL] = usb_side_full[sel_ep];
      bs_view[BS_CFULL] = cpu_side_full[sel_ep];
      bs_view[BS_DIR] = last_flow_direction[sel_ep];
      bs_view[BS_ESP] = 1'b0;
    end
  end

  // Unmapped addresses answer zero
  always_comb begin
    rd_mux = 8'h00;
    unique case (sfr_addr)
      SFR_EPBC: rd_mux = bc_view;
      SFR_EPBS: rd_mux = bs_view;
      SFR_ENDPOINT_SELECTOR: rd_mux = endpoint_selector_reg;
      SFR_OFFSET: rd_mux = {{(8-OFF_W){1'b0}}, cpu_buffer_offset_reg};
      SFR_DATA_PORT: rd_mux = buffer_data_port_reg;
      default: rd_mux = 8'h00;
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata_reg <= 8'h00;
    end else if (sfr_rd) begin
      rdata_reg <= rd_mux;
    end
  end

  assign sfr_rdata = rdata_reg;

  // ********
  // Status phase and interrupt gate
  // ********
  uebc_status_phase u_stat (
    .clk(clk),
    .rst(rst),
    .ep(usb_ep),
    .req(status_req),
    .done(status_done),
    .esp(status_phase_auto_ack),
    .halt(endpoint_halt),
    .ack(status_ack),
    .stall(status_stall),
    .esp_clr(esp_clr),
    .irq(status_phase_irq)
  );

  assign ep_irq = endpoint_irq_requests & endpoint_irq_gate;
endmodule
`default_nettype wire

// ### bench/uebc_host_model.sv
`timescale 1ns/10ps
`default_nettype none
module uebc_host_model import uebc_pkg::*; (
  input wire logic clk, // Clock
  output logic [EP_W-1:0] usb_ep = '0, // Endpoint
  output logic usb_setup, // Setup
  output logic usb_sof, // Frame
  output logic usb_token, // Token
  output logic usb_token_rd = '0, // Token dir
  output logic usb_wr_done, // Filled
  output logic usb_rd_done, // Drained
  output logic status_req, // Status start
  output logic status_done, // Status end
  output logic usb_mem_we = '0, // Mem write
  output logic [MEM_AW-1:0] usb_mem_addr = '0, // Mem address
  output logic [7:0] usb_mem_wdata = '0 // Mem byte
);
  // ****************************************
  // Host event and memory driver
  // ****************************************
  logic [6:0] pulse = '0;
  // One vector so that no two tasks fight over a strobe
  assign {status_done, status_req, usb_rd_done, usb_wr_done, usb_token,
    usb_sof, usb_setup} = pulse;
  // One event pulse, then time for flags to settle
  task automatic ev(input logic [6:0] k, input logic [EP_W-1:0] e);
    @(posedge clk);
    usb_ep <= e;
    pulse <= k;
    @(posedge clk);
    pulse <= '0;
    repeat (2) @(posedge clk);
  endtask
  // Single byte into endpoint memory
  task automatic mw(input logic [MEM_AW-1:0] a, input logic [7:0] d);
    @(posedge clk);
    usb_mem_we <= 1'b1;
    usb_mem_addr <= a;
    usb_mem_wdata <= d;
    @(posedge clk);
    usb_mem_we <= 1'b0;
    usb_mem_wdata <= ~d; // Released line shows no stale byte
  endtask
endmodule
`default_nettype wire

// ### bench/uebc_assertions.sv
`timescale 1ns/10ps
`default_nettype none
module uebc_assertions import uebc_pkg::*; (
  input wire logic clk, // Clock
  input wire logic rst, // Reset
  input wire logic [7:0] sfr_addr, // Address
  input wire logic sfr_wr, // Write
  input wire logic [EP_W-1:0] usb_ep, // Endpoint
  input wire logic usb_setup, // Setup
  input wire logic status_req, // Status start
  input wire logic status_done, // Status end
  input wire logic status_ack, // Auto ack
  input wire logic status_stall, // Stall
  input wire logic status_phase_irq, // Irq
  input wire logic [NUM_EP-1:0] endpoint_irq_requests, // Requests
  input wire logic [NUM_EP-1:0] ep_irq, // Gated irqs
  input wire logic [NUM_EP-1:0] endpoint_halt, // Halt
  input wire logic [NUM_EP-1:0] last_flow_direction, // Direction
  input wire logic [NUM_EP-1:0] usb_side_full, // Full
  input wire logic [NUM_EP-1:0] double_buffer_sel // Mode
);
  // ****************************************
  // Port relations
  // ****************************************
  logic ctl_wr;
  // Only control writes may raise halt bits or move mode bits
  assign ctl_wr = sfr_wr && sfr_addr == SFR_EPBC;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_auto_done;
    status_ack ##[1:4] status_done;
  endsequence
  property p_gate;
    (ep_irq & ~endpoint_irq_requests) == '0;
  endproperty
  a_gate: assert property (p_gate) else $error("irq not gated");
  property p_ack;
    status_ack |-> $past(status_req) && !$past(endpoint_halt[usb_ep]);
  endproperty
  a_ack: assert property (p_ack) else $error("bad auto ack");
  property p_stall;
    status_stall |-> $past(status_req && endpoint_halt[usb_ep]);
  endproperty
  a_stall: assert property (p_stall) else $error("bad stall");
  property p_excl;
    !(status_ack && status_stall);
  endproperty
  a_excl: assert property (p_excl) else $error("ack with stall");
  property p_quiet;
    s_auto_done |=> !status_phase_irq;
  endproperty
  a_quiet: assert property (p_quiet) else $error("irq after auto");
  property p_irq;
    status_phase_irq |-> $past(status_done);
  endproperty
  a_irq: assert property (p_irq) else $error("irq without done");
  property p_setup;
    usb_setup && usb_ep == 3'h0 && !ctl_wr |=> !endpoint_halt[0];
  endproperty
  a_setup: assert property (p_setup) else $error("halt kept");
  property p_halt;
    (endpoint_halt & ~$past(endpoint_halt)) != '0 |-> $past(ctl_wr);
  endproperty
  a_halt: assert property (p_halt) else $error("halt rose alone");
  property p_mode;
    $changed(double_buffer_sel) |-> $past(ctl_wr);
  endproperty
  a_mode: assert property (p_mode) else $error("mode moved");
  property p_dir;
    ((last_flow_direction ^ $past(last_flow_direction))
      & $past(usb_side_full)) == '0;
  endproperty
  a_dir: assert property (p_dir) else $error("dir moved full");
endmodule
bind uebc_top uebc_assertions chk_i (.clk, .rst, .sfr_addr, .sfr_wr,
  .usb_ep, .usb_setup, .status_req, .status_done, .status_ack,
  .status_stall, .status_phase_irq, .endpoint_irq_requests, .ep_irq,
  .endpoint_halt, .last_flow_direction, .usb_side_full, .double_buffer_sel);
`default_nettype wire

// ### bench/testbench.sv
`timescale 1ns/10ps
`default_nettype none
module testbench import uebc_pkg::*; ;
  // ****************************************
  // Bench signals and instances
  // ****************************************
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] sfr_addr = '0, sfr_wdata = '0, sfr_rdata, usb_mem_rdata;
  logic sfr_wr = 1'b0, sfr_rd = 1'b0;
  logic [NUM_EP-1:0] endpoint_irq_requests = '0;
  logic [EP_W-1:0] usb_ep;
  logic usb_setup, usb_sof, usb_token, usb_token_rd, usb_wr_done;
  logic usb_rd_done, status_req, status_done, usb_mem_we;
  logic [MEM_AW-1:0] usb_mem_addr;
  logic [7:0] usb_mem_wdata, n_ack = '0, n_stall = '0, n_irq = '0;
  logic status_ack, status_stall, status_phase_irq;
  logic [NUM_EP-1:0] ep_irq, endpoint_halt, last_flow_direction;
  logic [NUM_EP-1:0] usb_side_full, double_buffer_sel;
  int err_total = 0, n_checks = 0, cyc = 0;
  uebc_top dut (.clk, .rst, .sfr_addr, .sfr_wdata, .sfr_wr, .sfr_rd,
    .sfr_rdata, .usb_ep, .usb_setup, .usb_sof, .usb_token, .usb_token_rd,
    .usb_wr_done, .usb_rd_done, .usb_mem_we, .usb_mem_addr, .usb_mem_wdata,
    .usb_mem_rdata, .status_req, .status_done, .status_ack, .status_stall,
    .status_phase_irq, .endpoint_irq_requests, .ep_irq, .endpoint_halt,
    .last_flow_direction, .usb_side_full, .double_buffer_sel);
  uebc_host_model host (.clk, .usb_ep, .usb_setup, .usb_sof, .usb_token,
    .usb_token_rd, .usb_wr_done, .usb_rd_done, .status_req, .status_done,
    .usb_mem_we, .usb_mem_addr, .usb_mem_wdata);
  // Free running clock
  initial begin
    forever #5 clk = ~clk;
  end
  // One-cycle answers are counted so none slips between checks
  always @(posedge clk) begin
    n_ack <= n_ack + {7'h00, status_ack};
    n_stall <= n_stall + {7'h00, status_stall};
    n_irq <= n_irq + {7'h00, status_phase_irq};
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_total = err_total + 1;
      wrap_up;
    end
  end
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] seen, exp, input string nm);
    n_checks = n_checks + 1;
    if (seen !== exp) begin
      err_total = err_total + 1;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // Write strobe for one cycle, then an idle cycle for the port reload
  task automatic wr(input logic [7:0] a, d);
    @(posedge clk);
    sfr_addr <= a;
    sfr_wdata <= d;
    sfr_wr <= 1'b1;
    @(posedge clk);
    sfr_wr <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rc(input logic [7:0] a, exp, input string nm);
    @(posedge clk);
    sfr_addr <= a;
    sfr_rd <= 1'b1;
    @(posedge clk);
    sfr_rd <= 1'b0;
    @(posedge clk);
    chk(sfr_rdata, exp, nm);
  endtask
  task automatic dw(input logic [7:0] d, input logic exp);
    wr(SFR_EPBS, d);
    chk({7'h00, last_flow_direction[4]}, {7'h00, exp}, "dir4");
  endtask
  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_reset;
    rc(SFR_EPBC, 8'h00, "ctl rst");
    rc(SFR_EPBS, 8'h20, "sts rst");
    rc(8'h00, 8'h00, "unmapped");
  endtask
  task automatic t_halt;
    wr(SFR_ENDPOINT_SELECTOR, 8'h00);
    wr(SFR_EPBC, 8'h80);
    wr(SFR_ENDPOINT_SELECTOR, 8'h01);
    wr(SFR_EPBC, 8'h80);
    chk({3'h0, endpoint_halt}, 8'h03, "halt");
    host.ev(7'h01, 3'd1);
    chk({3'h0, endpoint_halt}, 8'h03, "halt ep1");
    host.ev(7'h01, 3'd0);
    chk({3'h0, endpoint_halt}, 8'h02, "halt ep0");
    rc(SFR_EPBC, 8'h80, "ctl ep1");
    wr(SFR_EPBC, 8'h00);
    chk({3'h0, endpoint_halt}, 8'h00, "active");
  endtask
  task automatic t_gate_mode;
    wr(SFR_ENDPOINT_SELECTOR, 8'h02);
    wr(SFR_EPBC, 8'h40);
    endpoint_irq_requests <= 5'h1f;
    @(posedge clk);
    chk({3'h0, ep_irq}, 8'h04, "gate on");
    wr(SFR_EPBC, 8'h01);
    chk({3'h0, ep_irq}, 8'h00, "gate off");
    chk({3'h0, double_buffer_sel}, 8'h04, "dual");
    wr(SFR_EPBC, 8'h00);
    endpoint_irq_requests <= 5'h00;
    chk({3'h0, double_buffer_sel}, 8'h00, "single");
  endtask
  task automatic t_fifo;
    wr(SFR_ENDPOINT_SELECTOR, 8'h00);
    wr(SFR_EPBC, 8'h02);
    wr(SFR_OFFSET, 8'h00);
    wr(SFR_DATA_PORT, 8'ha1);
    wr(SFR_DATA_PORT, 8'ha2);
    wr(SFR_DATA_PORT, 8'ha3);
    rc(SFR_OFFSET, 8'h03, "offset step");
    wr(SFR_OFFSET, 8'h01);
    rc(SFR_DATA_PORT, 8'ha2, "fetch");
    rc(SFR_DATA_PORT, 8'ha3, "fetch step");
    wr(SFR_EPBS, 8'h02);
    rc(SFR_OFFSET, 8'h00, "offset flush");
    wr(SFR_EPBC, 8'h00);
  endtask
  // Endpoint 4 starts CPU to host, single buffer
  task automatic t_flags;
    wr(SFR_ENDPOINT_SELECTOR, 8'h04);
    wr(SFR_EPBS, 8'h01);
    rc(SFR_EPBS, 8'he0, "done c2h");
    chk({3'h0, usb_side_full}, 8'h10, "usb full");
    dw(8'h04, 1'b1);
    wr(SFR_EPBS, 8'h02);
    rc(SFR_EPBS, 8'h20, "flush");
    wr(SFR_EPBC, 8'h20);
    host.ev(7'h02, 3'd4);
    rc(SFR_EPBS, 8'he0, "frame on");
    wr(SFR_EPBS, 8'h02);
    wr(SFR_EPBC, 8'h00);
    host.ev(7'h02, 3'd4);
    rc(SFR_EPBS, 8'h20, "frame off");
    dw(8'h06, 1'b1);
    dw(8'h0c, 1'b1);
    dw(8'h04, 1'b0);
    dw(8'h08, 1'b1);
    dw(8'h04, 1'b0);
    host.mw({3'd4, 1'b0, 4'h0}, 8'h5a);
    host.ev(7'h08, 3'd4);
    rc(SFR_EPBS, 8'hc0, "host fill");
    chk(usb_mem_rdata, 8'h5a, "usb byte");
    wr(SFR_OFFSET, 8'h00);
    rc(SFR_DATA_PORT, 8'h5a, "host byte");
    wr(SFR_EPBS, 8'h01);
    rc(SFR_EPBS, 8'h00, "done h2c");
    host.usb_token_rd <= 1'b1;
    host.ev(7'h04, 3'd4);
    chk({7'h00, last_flow_direction[4]}, 8'h01, "token");
    wr(SFR_EPBC, 8'h01);
    wr(SFR_EPBS, 8'h01);
    rc(SFR_EPBS, 8'ha0, "dual done");
    host.ev(7'h10, 3'd4);
    rc(SFR_EPBS, 8'h20, "host drain");
  endtask
  task automatic t_status;
    wr(SFR_ENDPOINT_SELECTOR, 8'h01);
    wr(SFR_EPBS, 8'h10);
    rc(SFR_EPBS, 8'h20, "arm reads 0");
    host.ev(7'h20, 3'd1);
    host.ev(7'h40, 3'd1);
    chk(n_ack, 8'h01, "auto ack");
    chk(n_irq, 8'h00, "auto quiet");
    host.ev(7'h20, 3'd1);
    host.ev(7'h40, 3'd1);
    chk(n_ack, 8'h01, "disarmed");
    chk(n_irq, 8'h01, "sw irq");
    wr(SFR_EPBS, 8'h10);
    wr(SFR_EPBC, 8'h80);
    host.ev(7'h20, 3'd1);
    host.ev(7'h40, 3'd1);
    chk(n_stall, 8'h01, "stall");
    chk(n_ack, 8'h01, "no ack halted");
    wr(SFR_EPBC, 8'h00);
  endtask
  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    t_reset;
    t_halt;
    t_gate_mode;
    t_fifo;
    t_flags;
    t_status;
    wrap_up;
  end
endmodule
`default_nettype wire
